// ### design/bcd_pkg.sv
// Notes on behaviour
// - bar input high is black, low white
// - zero and space one unit, one two
// - code opens with header of two zeros
// - code closes with tail one then zero
// - width counter runs while first black lasts
// - first sample at half width in white
// - half compare is latched width shifted right
// - later samples every full latched width
// - black then white decodes as zero
// - black black white decodes as one
// - other black patterns invalid, white white ends
// - eight shifted bits pull byte ready low
// - three bit gray bit counter, cleared
// - byte ready driven only at gray zero
// - data register shifts only on controller strobe
// - direction low means reverse, bytes bit-reversed
// - scan active high while code read
// - decode error high on illegal pattern
// - controller checks header, steers every part
// - header 00 forward, 01 reverse, else error
// - clear when idle and white, count in sync
// - direction set in forward, reset idle
// - active is not idle, error from error state
package bcd_pkg;

  // ****************************************
  // widths and register map
  // ****************************************
  localparam int RATE_W = 8;
  localparam int BYTE_W = 8;
  localparam int GRAY_W = 3;

  localparam logic [1:0] REG_DATA    = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h1;
  localparam logic [1:0] REG_CONTROL = 2'h2;

  localparam int ST_DIR      = 0;
  localparam int ST_ACT      = 1;
  localparam int ST_ERR      = 2;
  localparam int ST_IRQ      = 3;
  localparam int ST_GRAY_LSB = 4;
  localparam int CTRL_ENABLE = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  localparam logic [RATE_W-1:0] RATE_MAX = 8'hff;
  localparam logic [RATE_W-1:0] RATE_ONE = 8'h01;
  localparam logic [GRAY_W-1:0] GRAY_ZERO = 3'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    CtlIdle, CtlSync, CtlLatch, CtlHdr1, CtlHdr2, CtlHdr3, CtlFwd,
    CtlRev1, CtlRev2, CtlAct1, CtlAct2, CtlAct3, CtlAct4, CtlErr
  } bcd_ctl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [1:0]  address;
    logic [31:0] writedata;
  } bcd_avs_req_t;

  typedef struct packed {
    logic scanDirection;
    logic scanActive;
    logic decodeError;
  } bcd_status_t;

  typedef struct packed {
    logic [2:0]        barSync;
    logic              barLevel;
    bcd_ctl_t          ctl;
    logic [RATE_W-1:0] rateCnt;
    logic [RATE_W-1:0] widthLatch;
    logic              halfSel;
    logic [GRAY_W-1:0] gray;
    logic [BYTE_W-1:0] shiftData;
    logic              dirFlag;
    logic              errFlag;
    logic              ctlEnable;
    logic              busAck;
    logic [31:0]       readData;
  } bcd_state_t;

endpackage

// ### design/bcd_bar_code_decoder.sv
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bcd_bar_code_decoder (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // avalon-mm slave
  input  wire bcd_pkg::bcd_avs_req_t avsReq,
  output logic [31:0]            avsReadData,
  output logic                   avsWaitRequest,
  // light pen
  input  wire logic              barIn,
  // byte ready, open collector, active low
  output logic                   byteReadyNDrive,
  output logic                   byteReadyNEn,
  // data and status pins
  output logic [7:0]             dataByte,
  output bcd_pkg::bcd_status_t   status
);
  import bcd_pkg::*;

  initial begin
    if (RATE_W != 8 || BYTE_W != 8 || GRAY_W != 3) begin
      $error("unsupported width setting");
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [GRAY_W-1:0] grayNext(
    input logic [GRAY_W-1:0] g);
    unique case (g)
      3'h0: grayNext = 3'h1;
      3'h1: grayNext = 3'h3;
      3'h3: grayNext = 3'h2;
      3'h2: grayNext = 3'h6;
      3'h6: grayNext = 3'h7;
      3'h7: grayNext = 3'h5;
      3'h5: grayNext = 3'h4;
      3'h4: grayNext = 3'h0;
    endcase
  endfunction

  // half or full path of the mux; a zero compare would never be reached
  function automatic logic [RATE_W-1:0] cmpValue(
    input logic [RATE_W-1:0] w, input logic half);
    logic [RATE_W-1:0] v;
    v = half ? (w >> 1) : w;
    cmpValue = (v == '0) ? RATE_ONE : v;
  endfunction

  function automatic logic isSampling(input bcd_ctl_t c);
    isSampling = !(c inside {CtlIdle, CtlSync, CtlLatch});
  endfunction

  bcd_state_t q;
  bcd_state_t d;

  logic              bar;
  logic              zero;
  logic              counterClear;
  logic              widthCountUp;
  logic              halfWidthSelect;
  logic              bitShiftClock;
  logic              terminalCountEnable;
  logic [RATE_W-1:0] cmp;
  logic              busy;

  // ****************************************
  // decode of present state
  // ****************************************
  always_comb begin
    bar = q.barLevel;
    cmp = cmpValue(q.widthLatch, q.halfSel);
    zero = isSampling(q.ctl) && (q.rateCnt == cmp);
    counterClear = (q.ctl == CtlIdle) && !bar;
    widthCountUp = (q.ctl == CtlSync);
    halfWidthSelect = (q.ctl == CtlLatch);
    // a bit is complete once its trailing white is sampled
    bitShiftClock = zero && !bar &&
                    (q.ctl == CtlAct1 || q.ctl == CtlAct2);
    // only right after a shift, so the idle gray zero cannot fire
    terminalCountEnable = (q.ctl == CtlAct3) || (q.ctl == CtlAct4);
    busy = avsReq.read || avsReq.write;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.barSync = {q.barSync[1:0], barIn};
    if (q.barSync[1] == q.barSync[2]) begin
      d.barLevel = q.barSync[2];
    end

    // rate counter
    if (widthCountUp) begin
      if (q.rateCnt != RATE_MAX) begin
        d.rateCnt = q.rateCnt + RATE_ONE;
      end
    end else if (halfWidthSelect) begin
      d.widthLatch = q.rateCnt;
      d.rateCnt = RATE_ONE;
      d.halfSel = 1'b1;
    end else if (zero) begin
      d.rateCnt = RATE_ONE;
      d.halfSel = 1'b0;
    end else if (isSampling(q.ctl)) begin
      d.rateCnt = q.rateCnt + RATE_ONE;
    end else begin
      d.rateCnt = '0;
    end

    // controller
    unique case (q.ctl)
      CtlIdle: begin
        if (bar) begin
          d.ctl = CtlSync;
        end
      end
      CtlSync: begin
        if (!bar) begin
          d.ctl = CtlLatch;
        end
      end
      CtlLatch: d.ctl = CtlHdr1;
      CtlHdr1: begin
        if (zero) begin
          d.ctl = bar ? CtlErr : CtlHdr2;
        end
      end
      CtlHdr2: begin
        if (zero) begin
          d.ctl = bar ? CtlHdr3 : CtlErr;
        end
      end
      CtlHdr3: begin
        if (zero) begin
          d.ctl = bar ? CtlRev1 : CtlFwd;
        end
      end
      CtlFwd: begin
        if (zero) begin
          d.ctl = CtlAct1;
        end
      end
      CtlRev1: begin
        if (zero) begin
          d.ctl = bar ? CtlErr : CtlRev2;
        end
      end
      CtlRev2: begin
        if (zero) begin
          d.ctl = bar ? CtlAct1 : CtlErr;
        end
      end
      CtlAct1: begin
        if (zero) begin
          d.ctl = bar ? CtlAct2 : CtlAct3;
        end
      end
      CtlAct2: begin
        if (zero) begin
          d.ctl = bar ? CtlErr : CtlAct4;
        end
      end
      CtlAct3, CtlAct4: begin
        if (zero) begin
          d.ctl = bar ? CtlAct1 : CtlIdle;
        end
      end
      CtlErr: begin
        if (zero) begin
          d.ctl = CtlAct1;
        end
      end
    endcase
    if (!q.ctlEnable) begin
      d.ctl = CtlIdle;
    end

    // bit counter and data register
    if (counterClear) begin
      d.gray = GRAY_ZERO;
    end else if (bitShiftClock) begin
      d.gray = grayNext(q.gray);
    end
    if (bitShiftClock) begin
      d.shiftData = {q.shiftData[BYTE_W-2:0],
                     q.ctl == CtlAct2};
    end

    // status flags
    if (q.ctl == CtlIdle) begin
      d.dirFlag = 1'b0;
      d.errFlag = 1'b0;
    end else begin
      if (q.ctl == CtlFwd) begin
        d.dirFlag = 1'b1;
      end
      if (q.ctl == CtlErr) begin
        d.errFlag = 1'b1;
      end
    end

    // bus: one wait cycle, then the answer
    d.busAck = busy && !q.busAck;
    if (busy && !q.busAck) begin
      unique case (avsReq.address)
        REG_DATA: d.readData = {24'h0, q.shiftData};
        REG_STATUS: begin
          d.readData = '0;
          d.readData[ST_DIR] = q.dirFlag;
          d.readData[ST_ACT] = q.ctl != CtlIdle;
          d.readData[ST_ERR] = q.errFlag;
          d.readData[ST_IRQ] = byteReadyNEn;
          d.readData[ST_GRAY_LSB +: GRAY_W] = q.gray;
        end
        REG_CONTROL: d.readData = {31'h0, q.ctlEnable};
        default: d.readData = '0;
      endcase
    end
    if (avsReq.write && q.busAck && avsReq.address == REG_CONTROL) begin
      d.ctlEnable = avsReq.writedata[CTRL_ENABLE];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '{barSync: 3'h0, barLevel: 1'b0, ctl: CtlIdle,
             rateCnt: 8'h0, widthLatch: 8'h0, halfSel: 1'b0,
             gray: 3'h0, shiftData: 8'h0, dirFlag: 1'b0,
             errFlag: 1'b0, ctlEnable: CTRL_ENABLE_RST,
             busAck: 1'b0, readData: 32'h0};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    avsReadData = q.readData;
    avsWaitRequest = busy && !q.busAck;
    byteReadyNDrive = 1'b0;
    byteReadyNEn = terminalCountEnable
                   && q.gray == GRAY_ZERO;
    dataByte = q.shiftData;
    status.scanDirection = q.dirFlag;
    status.scanActive = q.ctl != CtlIdle;
    status.decodeError = q.errFlag;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence fwdHeader;
    q.ctl == CtlHdr3 && zero && !bar && q.ctlEnable ##1 q.ctl == CtlFwd;
  endsequence

  sequence zeroBit;
    q.ctl == CtlAct1 && zero && !bar && q.ctlEnable;
  endsequence

  sync_start_a: assert property (
    q.ctl == CtlIdle && bar && q.ctlEnable |=> q.ctl == CtlSync)
    else $error("black did not start width count");
  latch_width_a: assert property (
    q.ctl == CtlSync && !bar |=> ##1 q.widthLatch == $past(q.rateCnt))
    else $error("width latch wrong");
  half_cmp_a: assert property (
    q.ctl == CtlLatch |=> cmp == cmpValue(q.widthLatch, 1'b1) && q.halfSel)
    else $error("first compare not half width");
  full_cmp_a: assert property (
    zero && q.halfSel |=> !q.halfSel && q.rateCnt == RATE_ONE)
    else $error("later compare not full width");
  zero_bit_a: assert property (
    zeroBit |=> q.ctl == CtlAct3 && q.shiftData[0] == 1'b0
      && q.gray == grayNext($past(q.gray)))
    else $error("zero bit decode wrong");
  one_bit_a: assert property (
    q.ctl == CtlAct2 && zero && !bar && q.ctlEnable
      |=> q.ctl == CtlAct4 && q.shiftData[0] == 1'b1)
    else $error("one bit decode wrong");
  bad_one_a: assert property (
    q.ctl == CtlAct2 && zero && bar && q.ctlEnable |=> q.ctl == CtlErr
      ##1 status.decodeError)
    else $error("triple black not flagged");
  code_end_a: assert property (
    (q.ctl == CtlAct3 || q.ctl == CtlAct4) && zero && !bar
      |=> q.ctl == CtlIdle)
    else $error("two whites did not end code");
  fwd_dir_a: assert property (
    fwdHeader |=> status.scanDirection)
    else $error("forward header did not set direction");
  byte_irq_a: assert property (
    byteReadyNEn |-> $past(bitShiftClock) && q.gray == GRAY_ZERO
      || $past(byteReadyNEn))
    else $error("byte ready without eighth bit");
  gray_clr_a: assert property (
    counterClear |=> q.gray == GRAY_ZERO)
    else $error("bit counter not cleared");
  bus_wait_a: assert property (
    busy && !q.busAck |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("bus answer not one wait cycle");

endmodule
`default_nettype wire

// ### verification/bcd_pen_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_pen_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // sweep request, first unit in bit len-1
  input  wire logic        go,
  input  wire logic [31:0] levels,
  input  wire logic [5:0]  len,
  input  wire logic [7:0]  unitCycles,
  // pen level and progress
  output var logic         barIn,
  output var logic         busy
);
  // ****************************************
  // constant speed sweep, one level per unit
  // ****************************************
  initial begin
    barIn = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go && !srst) begin
        busy <= 1'b1;
        for (int i = int'(len) - 1; i >= 0; i--) begin
          barIn <= levels[i];
          repeat (int'(unitCycles)) @(posedge clock);
        end
        // pen lifted: white until the next sweep
        barIn <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bcd_pkg::*;
  // ****************************************
  // sweeps: levels, units, {dir,act,err} seen, bytes
  // ****************************************
  localparam logic [31:0] LV [4] = '{32'h15ad5ada, 32'h0000002d,
                                     32'h00000057, 32'h00000002};
  localparam logic [5:0]  LN [4] = '{6'h1d, 6'h06, 6'h07, 6'h02};
  localparam logic [2:0]  SN [4] = '{3'h6, 3'h2, 3'h7, 3'h3};
  localparam logic [1:0]  RC [4] = '{2'h1, 2'h0, 2'h0, 2'h0};
  logic         clock;
  logic         srst;
  logic         barIn;
  logic         go;
  logic         penBusy;
  logic         scanClr;
  logic         irqPrev;
  logic         avsWaitRequest;
  logic         byteReadyNDrive;
  logic         byteReadyNEn;
  logic [31:0]  avsReadData;
  logic [31:0]  penLv;
  logic [31:0]  rd;
  logic [7:0]   dataByte;
  logic [7:0]   byteSeen;
  logic [5:0]   penLn;
  logic [2:0]   seen;
  logic [1:0]   readyCnt;
  bcd_avs_req_t avsReq;
  bcd_status_t  status;
  int           err_total;
  int           check_count;
  // open-collector line with its pull-up
  wire logic    irqN = byteReadyNEn ? byteReadyNDrive : 1'b1;

  bcd_bar_code_decoder dut_u (
    .clock(clock), .srst(srst), .avsReq(avsReq),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .barIn(barIn), .byteReadyNDrive(byteReadyNDrive),
    .byteReadyNEn(byteReadyNEn), .dataByte(dataByte), .status(status));
  bcd_pen_model pen_u (
    .clock(clock), .srst(srst), .go(go), .levels(penLv), .len(penLn),
    .unitCycles(8'h10), .barIn(barIn), .busy(penBusy));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // sticky flags and byte-ready falls over one sweep
  always @(posedge clock) begin
    irqPrev <= irqN;
    if (scanClr) begin
      seen <= 3'h0;
      readyCnt <= 2'h0;
    end else begin
      seen <= seen | status;
      if (irqPrev && !irqN) begin
        readyCnt <= readyCnt + 2'h1;
        byteSeen <= dataByte;
      end
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avsReq <= '{read: !wr, write: wr, address: a, writedata: wd};
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    d = avsReadData;
    avsReq <= '0;
    if (n == 50) begin
      err_total++;
      $display("CHECK FAILED t=%0t bus hang", $time);
    end
  endtask

  task automatic run_scan(input logic [31:0] lv, input logic [5:0] ln);
    int n;
    n = 0;
    @(posedge clock);
    penLv <= lv;
    penLn <= ln;
    go <= 1'b1;
    scanClr <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    scanClr <= 1'b0;
    repeat (2) @(posedge clock);
    while ((penBusy === 1'b1 || status.scanActive !== 1'b0) && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (n == 2000) begin
      err_total++;
      $display("CHECK FAILED t=%0t scan never ended", $time);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    avsReq = '0;
    go = 1'b0;
    scanClr = 1'b0;
    penLv = '0;
    penLn = '0;
    err_total = 0;
    check_count = 0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk({29'h0, status}, 32'h0, "status pins");
    chk({24'h0, dataByte}, 32'h0, "data pins");
    chk({31'h0, byteReadyNEn}, 32'h0, "byte ready idle");
    bus(1'b0, REG_CONTROL, 32'h0, rd);
    chk(rd, 32'h1, "control reset");
    // writes elsewhere than control must change nothing
    for (int a = 0; a < 4; a++) begin
      if (a != 2) begin
        bus(1'b1, 2'(a), 32'hffffffff, rd);
        bus(1'b0, 2'(a), 32'h0, rd);
        chk(rd, 32'h0, "read-only or unmapped");
      end
    end
    for (int i = 0; i < 4; i++) begin
      run_scan(LV[i], LN[i]);
      chk({29'h0, seen}, {29'h0, SN[i]}, "flags seen");
      chk({30'h0, readyCnt}, {30'h0, RC[i]}, "byte ready");
      bus(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd, 32'h0, "status after end");
      if (i == 0) begin
        chk({24'h0, byteSeen}, 32'ha5, "byte at ready");
        bus(1'b0, REG_DATA, 32'h0, rd);
        chk(rd, 32'h96, "byte after tail");
      end
    end
    bus(1'b1, REG_CONTROL, 32'h0, rd);
    bus(1'b0, REG_CONTROL, 32'h0, rd);
    chk(rd, 32'h0, "control cleared");
    run_scan(LV[0], LN[0]);
    chk({29'h0, seen}, 32'h0, "disabled stays idle");
    bus(1'b1, REG_CONTROL, 32'h1, rd);
    run_scan(LV[2], LN[2]);
    chk({29'h0, seen}, 32'h7, "error after enable");
    finish_test();
  end
endmodule
`default_nettype wire
